/* File: verilog/uc_cfg_consts.svh */
// Constants for the average-undercurrent threshold and global option word block
`ifndef UC_CFG_CONSTS_SVH
`define UC_CFG_CONSTS_SVH
// Command codes of the two registers
`define CMD_AVG_UC_THR 8'he8
`define CMD_GLOBAL_OPT 8'he9
// Global option word field positions
`define GOW_MON_TEMP_BIT 12
`define GOW_SENSE_LSB 8
`define GOW_DDC_PP_BIT 6
`define GOW_TMO_DIS_BIT 4
`define GOW_SYNC_LSB 1
// Field codes
`define SENSE_SHARED 2'h1
`define SYNC_INT_OUT 2'h1
`define SYNC_EXT 2'h2
// Linear-11 layout: exponent in 15:11, mantissa in 10:0
`define L11_EXP_LSB 11
`define L11_MANT_MIN 11'h400
`define L11_MANT_HALF 11'h200
// Current samples are signed with this many fraction bits (1/16 A)
`define CUR_FRAC_BITS 4
`define CUR_LIMIT_AMPS 100
`define CUR_LIMIT_FIXED ((`CUR_LIMIT_AMPS) << (`CUR_FRAC_BITS))
// Reset values before the strap load
`define THR_RESET 16'h0000
`define GOW_RESET 16'h0000
// Cycles after reset release before the synchronised straps are taken
`define STRAP_SETTLE_CYCLES 3'h3
`define ACC_CNT_MAX 8'hff
`endif

/* File: verilog/uc_cfg_pkg.sv */
// Types for the average-undercurrent threshold and global option word block
package uc_cfg_pkg;
  // One command from the link front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] code;
    logic page;
    logic [15:0] data;
  } cmd_req_type;
  // One current sample of one output
  typedef struct packed {
    logic valid;
    logic signed [15:0] value;
    logic on_interval;
    logic blanking;
  } sample_type;
  // Whole state of the block
  typedef struct packed {
    logic [1:0][15:0] uc_thr;
    logic [15:0] gow;
    logic [1:0][15:0] strap_oc_s1;
    logic [1:0][15:0] strap_oc_s2;
    logic [15:0] strap_gow_s1;
    logic [15:0] strap_gow_s2;
    logic [2:0] load_cnt;
    logic loaded;
    logic [1:0][23:0] acc_sum;
    logic [1:0][7:0] acc_cnt;
    logic [1:0] prev_active;
    logic [1:0] uc_flag;
    logic [1:0] resp_pulse;
    logic [15:0] rd_data;
    logic rd_valid;
    logic rd_error;
    logic wr_refused;
  } state_type;
endpackage

/* File: verilog/uc_cfg_block.sv */
// Average-undercurrent threshold, undercurrent fault flag and global option word
`timescale 1ns/1ps
`default_nettype none
`include "uc_cfg_consts.svh"

module uc_cfg_block (
  input wire logic mclk,
  input wire logic rst_n,
  input wire uc_cfg_pkg::cmd_req_type cmd,
  input wire logic write_protect,
  input wire logic clear_faults,
  input wire logic [1:0][15:0] strap_avg_oc,
  input wire logic [15:0] strap_global,
  input wire uc_cfg_pkg::sample_type [1:0] samples,
  input wire logic [1:0] slope_up,
  input wire logic [1:0] instant_uc,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic rd_error,
  output logic wr_refused,
  output logic cfg_loaded,
  output logic [1:0] uc_fault_flag,
  output logic [1:0] uc_fault_event,
  output logic alert_line_out,
  output logic alert_line_oe_n,
  output logic monitor_is_temp,
  output logic [1:0] sense_sel,
  output logic inter_device_comm_push_pull,
  output logic bus_timeout_en,
  output logic sync_use_external,
  output logic sync_drive_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Linear-11 to signed fixed point with CUR_FRAC_BITS fraction bits
  function automatic logic signed [31:0] l11_to_fixed(input logic [15:0] w);
    logic signed [31:0] m;
    logic signed [5:0] sh;
    m = 32'(signed'(w[`L11_EXP_LSB-1:0]));
    sh = 6'(signed'(w[15:`L11_EXP_LSB])) + 6'(`CUR_FRAC_BITS);
    if (sh >= 0) begin
      return m <<< sh;
    end else begin
      return m >>> (-sh);
    end
  endfunction

  // Negate a Linear-11 value; the most negative mantissa moves up one exponent
  function automatic logic [15:0] l11_negate(input logic [15:0] w);
    if (w[`L11_EXP_LSB-1:0] == `L11_MANT_MIN) begin
      return {5'(w[15:`L11_EXP_LSB] + 5'h01), `L11_MANT_HALF};
    end else begin
      return {w[15:`L11_EXP_LSB], 11'(-w[`L11_EXP_LSB-1:0])};
    end
  endfunction

  // Threshold lies inside the accepted current span
  function automatic logic thr_in_range(input logic [15:0] w);
    logic signed [31:0] f;
    f = l11_to_fixed(w);
    return (f >= -(`CUR_LIMIT_FIXED)) && (f <= (`CUR_LIMIT_FIXED));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  uc_cfg_pkg::state_type st;  // All registers
  uc_cfg_pkg::state_type next_st;  // Next value of all registers
  logic [1:0] active;  // Sample lies in the averaged interval
  logic [1:0] interval_end;  // Averaged interval just ended
  logic [1:0] avg_viol;  // Average fell below threshold
  logic signed [23:0] mean [2];  // Average of the last interval

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  // Strap load, averaging, fault flags and command handling
  always_comb begin
    next_st = st;
    // Straps come from pins: two flip-flops before use
    next_st.strap_oc_s1 = strap_avg_oc;
    next_st.strap_oc_s2 = st.strap_oc_s1;
    next_st.strap_gow_s1 = strap_global;
    next_st.strap_gow_s2 = st.strap_gow_s1;
    next_st.resp_pulse = 2'h0;
    next_st.rd_valid = 1'b0;
    next_st.rd_error = 1'b0;
    next_st.wr_refused = 1'b0;
    // Configuration load once the straps have settled
    if (!st.loaded) begin
      if (st.load_cnt == `STRAP_SETTLE_CYCLES) begin
        next_st.loaded = 1'b1;
        next_st.gow = st.strap_gow_s2;
        for (int i = 0; i < 2; i++) begin
          next_st.uc_thr[i] = l11_negate(st.strap_oc_s2[i]);
        end
      end else begin
        next_st.load_cnt = 3'(st.load_cnt + 3'h1);
      end
    end
    // Per-page averaging of current samples
    for (int i = 0; i < 2; i++) begin
      // Up-slope averages the on interval, down-slope the off interval
      active[i] = slope_up[i] ? samples[i].on_interval : !samples[i].on_interval;
      interval_end[i] = st.prev_active[i] && !active[i];
      mean[i] = $signed(st.acc_sum[i]) / $signed({16'h0000, st.acc_cnt[i]});
      avg_viol[i] = 1'b0;
      next_st.prev_active[i] = active[i];
      if (interval_end[i]) begin
        // An empty interval (all blanked) gives no verdict
        if (st.acc_cnt[i] != 8'h00) begin
          avg_viol[i] = 32'(mean[i]) < l11_to_fixed(st.uc_thr[i]);
        end
        next_st.acc_sum[i] = 24'h000000;
        next_st.acc_cnt[i] = 8'h00;
      end else if (active[i] && samples[i].valid && !samples[i].blanking
                   && st.acc_cnt[i] != `ACC_CNT_MAX) begin
        // Counter saturates so that the sum cannot wrap
        next_st.acc_sum[i] = 24'(st.acc_sum[i] + 24'(samples[i].value));
        next_st.acc_cnt[i] = 8'(st.acc_cnt[i] + 8'h01);
      end
      // Shared flag: the set wins over a clear in the same cycle
      if (clear_faults) begin
        next_st.uc_flag[i] = 1'b0;
      end
      if (avg_viol[i] || instant_uc[i]) begin
        next_st.uc_flag[i] = 1'b1;
        next_st.resp_pulse[i] = !st.uc_flag[i];
      end
    end
    // Register writes
    if (cmd.wr) begin
      if (write_protect) begin
        next_st.wr_refused = 1'b1;
      end else if (cmd.code == `CMD_AVG_UC_THR) begin
        if (thr_in_range(cmd.data)) begin
          next_st.uc_thr[cmd.page] = cmd.data;
        end else begin
          next_st.wr_refused = 1'b1;
        end
      end else if (cmd.code == `CMD_GLOBAL_OPT) begin
        // Page is ignored; unused bits are stored but steer nothing
        next_st.gow = cmd.data;
      end else begin
        next_st.wr_refused = 1'b1;
      end
    end
    // Register reads
    if (cmd.rd) begin
      next_st.rd_valid = 1'b1;
      if (cmd.code == `CMD_AVG_UC_THR) begin
        next_st.rd_data = st.uc_thr[cmd.page];
      end else if (cmd.code == `CMD_GLOBAL_OPT) begin
        next_st.rd_data = st.gow;
      end else begin
        next_st.rd_data = 16'h0000;
        next_st.rd_error = 1'b1;
      end
    end
  end

  // State register with synchronous reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= '0;
      st.gow <= `GOW_RESET;
      st.uc_thr <= {2{`THR_RESET}};
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Answers of the command port, load status and fault outputs
  assign rd_data = st.rd_data;
  assign rd_valid = st.rd_valid;
  assign rd_error = st.rd_error;
  assign wr_refused = st.wr_refused;
  assign cfg_loaded = st.loaded;
  assign uc_fault_flag = st.uc_flag;
  assign uc_fault_event = st.resp_pulse;

  // Alert is open drain: drive low while any flag stands
  assign alert_line_out = 1'b0;
  assign alert_line_oe_n = ~|st.uc_flag;

  // Decode of the global option word; unused codes act as the default
  assign monitor_is_temp = st.gow[`GOW_MON_TEMP_BIT];
  assign sense_sel[0] = 1'b0;
  assign sense_sel[1] = st.gow[`GOW_SENSE_LSB +: 2] != `SENSE_SHARED;
  assign inter_device_comm_push_pull = st.gow[`GOW_DDC_PP_BIT];
  assign bus_timeout_en = !st.gow[`GOW_TMO_DIS_BIT];
  // Clock-out mode relies on the host not using it with a strapped frequency
  assign sync_use_external = st.gow[`GOW_SYNC_LSB +: 2] == `SYNC_EXT;
  assign sync_drive_out = st.gow[`GOW_SYNC_LSB +: 2] == `SYNC_INT_OUT;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_wp_refuse;
    cmd.wr && write_protect |=> wr_refused && $stable(st.uc_thr) && $stable(st.gow);
  endproperty
  a_wp_refuse: assert property (p_wp_refuse) else $error("protected write taken");

  property p_range;
    cmd.wr && !write_protect && cmd.code == `CMD_AVG_UC_THR && !thr_in_range(cmd.data)
      |=> wr_refused && $stable(st.uc_thr);
  endproperty
  a_range: assert property (p_range) else $error("out-of-range threshold taken");

  property p_read_back;
    cmd.rd && cmd.code == `CMD_GLOBAL_OPT |=> rd_valid && !rd_error && rd_data == $past(st.gow);
  endproperty
  a_read_back: assert property (p_read_back) else $error("global word read wrong");

  property p_load;
    $rose(st.loaded) |-> st.uc_thr[0] == l11_negate($past(st.strap_oc_s2[0]))
      && st.gow == $past(st.strap_gow_s2);
  endproperty
  a_load: assert property (p_load) else $error("strap load wrong");

  property p_viol_flag;
    avg_viol[1] |=> uc_fault_flag[1] ##0 !alert_line_oe_n;
  endproperty
  a_viol_flag: assert property (p_viol_flag) else $error("violation not flagged");

  property p_flag_hold;
    uc_fault_flag[0] && !clear_faults |=> uc_fault_flag[0] [*2] or clear_faults;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped early");

  property p_blank;
    samples[0].valid && samples[0].blanking && !interval_end[0] |=> $stable(st.acc_cnt[0]);
  endproperty
  a_blank: assert property (p_blank) else $error("blanked sample counted");

  property p_sense;
    st.gow[`GOW_SENSE_LSB +: 2] == `SENSE_SHARED |-> sense_sel == 2'h0;
  endproperty
  a_sense: assert property (p_sense) else $error("sense routing wrong");

  property p_sync;
    !(sync_use_external && sync_drive_out) && (bus_timeout_en != st.gow[`GOW_TMO_DIS_BIT]);
  endproperty
  a_sync: assert property (p_sync) else $error("sync or timeout decode wrong");

  // The response pulse marks a flag going from clear to set, never a flag already set
  property p_event_once;
    uc_fault_event[0] |=> !uc_fault_event[0];
  endproperty
  a_event_once: assert property (p_event_once) else $error("response fired twice");

  // A response pulse always comes with its flag standing
  property p_event_flag;
    uc_fault_event[1] |-> uc_fault_flag[1];
  endproperty
  a_event_flag: assert property (p_event_flag) else $error("response without flag");

  // Clear-faults with no new violation drops the flag at the next edge
  property p_clear;
    clear_faults && !instant_uc[0] && !avg_viol[0] |=> !uc_fault_flag[0];
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");

  // A fault arriving with clear-faults must not be lost
  property p_set_wins;
    clear_faults && instant_uc[1] |=> uc_fault_flag[1];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("fault lost at clear");

  // An open write of the global word lands whatever page it names
  property p_gow_write;
    st.loaded && cmd.wr && !write_protect && cmd.code == `CMD_GLOBAL_OPT
      |=> st.gow == $past(cmd.data) && !wr_refused;
  endproperty
  a_gow_write: assert property (p_gow_write) else $error("global word write lost");

  // Writing one page's threshold leaves the other page alone
  property p_page_sep;
    st.loaded && cmd.wr && !write_protect && cmd.code == `CMD_AVG_UC_THR
      && thr_in_range(cmd.data)
      |=> st.uc_thr[~$past(cmd.page)] == $past(st.uc_thr[~cmd.page]);
  endproperty
  a_page_sep: assert property (p_page_sep) else $error("other page disturbed");

  // Read answers only follow a read request
  property p_rd_pulse;
    rd_valid |-> $past(cmd.rd);
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read answer without request");

  // The strap load happens once; later strap movement must not reload
  property p_loaded_stays;
    cfg_loaded |=> cfg_loaded;
  endproperty
  a_loaded_stays: assert property (p_loaded_stays) else $error("load dropped");

  // Main scenarios worth seeing in a run
  c_viol: cover property (avg_viol[0] ##1 uc_fault_event[0]);
  c_up_avg: cover property (slope_up[1] && interval_end[1] && st.acc_cnt[1] != 8'h00);
  c_clear: cover property (uc_fault_flag[1] ##1 clear_faults ##1 !uc_fault_flag[1]);
  c_wp: cover property (cmd.wr && write_protect);

endmodule // uc_cfg_block
`default_nettype wire

/* File: tb/host_model.sv */
// Host-side model that issues one register command at a time and samples the answer
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic mclk,
  output var uc_cfg_pkg::cmd_req_type cmd,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic rd_error,
  input wire logic wr_refused
);
  // Answer captured just after the edge that took the command
  logic [15:0] got_data;
  logic [2:0] got_flags;
  initial cmd = '0;
  // Command stands for exactly one edge; answer pulses last one cycle, so sample then
  task automatic access(input logic wr, input logic rd, input logic [7:0] code,
                        input logic page, input logic [15:0] data);
    @(posedge mclk);
    cmd <= '{wr, rd, code, page, data};
    @(posedge mclk);
    cmd <= '0;
    #1;
    got_data = rd_data;
    got_flags = {rd_valid, rd_error, wr_refused};
  endtask
endmodule // host_model
`default_nettype wire

/* File: tb/test_pmbus_avg_uc_limit_global_config.sv */
// Self-checking bench for the undercurrent threshold and global option word block
`timescale 1ns/1ps
`default_nettype none
module test_pmbus_avg_uc_limit_global_config;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic write_protect = 1'b0;
  logic clear_faults = 1'b0;
  // Strapped overcurrent: page 0 is 20 A, page 1 is 25 A
  logic [1:0][15:0] strap_avg_oc = {16'hf832, 16'h0014};
  logic [15:0] strap_global = 16'h1052;
  uc_cfg_pkg::sample_type [1:0] samples = '0;
  logic [1:0] slope_up = 2'h0;
  logic [1:0] instant_uc = 2'h0;
  uc_cfg_pkg::cmd_req_type cmd;
  logic [15:0] rd_data, lf, w;
  logic rd_valid, rd_error, wr_refused, cfg_loaded, alert_line_out, alert_line_oe_n;
  logic [1:0] uc_fault_flag, uc_fault_event, sense_sel;
  logic monitor_is_temp, inter_device_comm_push_pull, bus_timeout_en;
  logic sync_use_external, sync_drive_out;
  int num_errors = 0;
  int comparisons = 0;
  always #5 mclk = ~mclk;
  uc_cfg_block uut (.mclk(mclk), .rst_n(rst_n), .cmd(cmd), .write_protect(write_protect),
    .clear_faults(clear_faults), .strap_avg_oc(strap_avg_oc), .strap_global(strap_global),
    .samples(samples), .slope_up(slope_up), .instant_uc(instant_uc), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_error(rd_error), .wr_refused(wr_refused),
    .cfg_loaded(cfg_loaded), .uc_fault_flag(uc_fault_flag), .uc_fault_event(uc_fault_event),
    .alert_line_out(alert_line_out), .alert_line_oe_n(alert_line_oe_n),
    .monitor_is_temp(monitor_is_temp), .sense_sel(sense_sel),
    .inter_device_comm_push_pull(inter_device_comm_push_pull),
    .bus_timeout_en(bus_timeout_en), .sync_use_external(sync_use_external),
    .sync_drive_out(sync_drive_out));
  host_model host (.mclk(mclk), .cmd(cmd), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_error(rd_error), .wr_refused(wr_refused));
  ////////////////////////////////////////////////////////////////////////////////
  // Random source, expectations and comparison
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Negation in Linear-11; the most negative mantissa cannot flip, so halve it
  function automatic logic [15:0] neg11(input logic [15:0] v);
    if (v[10:0] == 11'h400) return {v[15:11] + 5'h1, 11'h200};
    return {v[15:11], 11'(-v[10:0])};
  endfunction
  // Unused sense and sync codes fall back to the default routing and clock
  function automatic logic [6:0] decode(input logic [15:0] g);
    return {g[12], (g[9:8] == 2'h1) ? 2'h0 : 2'h2, g[6], ~g[4], g[2:1] == 2'h2,
            g[2:1] == 2'h1};
  endfunction
  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Bus and sample helpers
  task automatic rd(input logic [7:0] code, input logic page, input logic [15:0] exp);
    host.access(1'b0, 1'b1, code, page, 16'h0000);
    check("read", {1'b0, host.got_flags, host.got_data}, {4'h4, exp});
  endtask
  task automatic wr(input logic [7:0] code, input logic page, input logic [15:0] d,
                    input logic refused);
    host.access(1'b1, 1'b0, code, page, d);
    check("write answer", 20'(host.got_flags), 20'(refused));
  endtask
  task automatic chk_decode(input logic [15:0] g);
    check("decode", 20'({monitor_is_temp, sense_sel, inter_device_comm_push_pull,
      bus_timeout_en, sync_use_external, sync_drive_out}), 20'(decode(g)));
  endtask
  // Two blanking samples far below any limit open the interval, then n real ones
  task automatic interval(input int p, input logic up, input int n, input logic [15:0] v,
                          input logic exp);
    logic seen;
    slope_up[p] <= up;
    // The last value stays idle, so the event pulse falls inside the watch window below
    for (int i = 0; i < n + 3; i++) begin
      @(posedge mclk);
      samples[p] <= '{i < n + 2, i < 2 ? 16'h8000 : v, (i < n + 2) ? up : ~up, i < 2};
    end
    seen = 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      #1;
      seen |= uc_fault_event[p];
    end
    check("fault event", 20'(seen), 20'(exp));
    check("alert", 20'({alert_line_oe_n, alert_line_out}), 20'({~exp, 1'b0}));
  endtask
  task automatic clear;
    @(posedge mclk);
    clear_faults <= 1'b1;
    @(posedge mclk);
    clear_faults <= 1'b0;
    @(posedge mclk);
    #1;
    check("cleared", 20'({uc_fault_flag, alert_line_oe_n}), 20'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    lf = 16'ha18d;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 12 && cfg_loaded !== 1'b1; i++) @(posedge mclk);
    if (cfg_loaded !== 1'b1) begin
      num_errors++;
      summarize();
    end
    rd(8'he8, 1'b0, neg11(strap_avg_oc[0]));
    rd(8'he8, 1'b1, neg11(strap_avg_oc[1]));
    rd(8'he9, 1'b1, strap_global);
    chk_decode(strap_global);
    // Corner codes first, then random words; host keeps unused bits zero
    // Switching frequency is taken as not strapped, so clock-out mode is allowed here
    for (int i = 0; i < 16; i++) begin
      w = (i == 3) ? 16'h0006 : (i < 3) ? {6'h00, 2'(i + 1), 8'h00} : lf & 16'h1356;
      lf = lfsr(lf);
      wr(8'he9, lf[0], w, 1'b0);
      rd(8'he9, ~lf[0], w);
      chk_decode(w);
    end
    // Range limits are inclusive at 100 A either way
    wr(8'he8, 1'b1, 16'h0064, 1'b0);
    rd(8'he8, 1'b0, neg11(strap_avg_oc[0]));
    wr(8'he8, 1'b0, 16'h079c, 1'b0);
    wr(8'he8, 1'b0, 16'h0065, 1'b1);
    wr(8'he8, 1'b0, 16'h079b, 1'b1);
    wr(8'he8, 1'b0, 16'hf8c9, 1'b1);
    rd(8'he8, 1'b0, 16'h079c);
    rd(8'he8, 1'b1, 16'h0064);
    // Protection refuses both commands; only the global word is read back to show it untouched
    write_protect <= 1'b1;
    wr(8'he9, 1'b0, 16'h0000, 1'b1);
    wr(8'he8, 1'b0, 16'h0002, 1'b1);
    rd(8'he9, 1'b0, w);
    write_protect <= 1'b0;
    host.access(1'b0, 1'b1, 8'he7, 1'b0, 16'hffff);
    check("unmapped", {1'b0, host.got_flags, host.got_data}, 20'h60000);
    // Limit of 2 A on both pages, samples in 1/16 A
    wr(8'he8, 1'b0, 16'h0002, 1'b0);
    wr(8'he8, 1'b1, 16'h0002, 1'b0);
    interval(0, 1'b0, 4, 16'h0010, 1'b1);
    clear();
    interval(0, 1'b0, 4, 16'h0030, 1'b0);
    interval(1, 1'b1, 5, 16'h0010, 1'b1);
    clear();
    @(posedge mclk);
    instant_uc <= 2'h1;
    @(posedge mclk);
    instant_uc <= 2'h0;
    repeat (2) @(posedge mclk);
    #1;
    check("instant flag", 20'(uc_fault_flag), 20'h1);
    clear();
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      interval(i % 2, lf[8], 3, {9'h000, lf[6:0]}, lf[6:0] < 7'h20);
      clear();
    end
    summarize();
  end
endmodule // test_pmbus_avg_uc_limit_global_config
`default_nettype wire
